/* File: design/dsgsr_pkg.sv */
`default_nettype none
package dsgsr_pkg;
	// ==========================================
	// register offsets (byte addresses)
	localparam logic [11:0] DSGSR_SOFT_RESET_0_OFS = 12'h040;
	localparam logic [11:0] DSGSR_RUN_GATE_OFS = 12'h100;
	localparam logic [11:0] DSGSR_SLEEP_GATE_OFS = 12'h118;
	localparam logic [11:0] DSGSR_DEEP_GATE_OFS = 12'h128;
	localparam logic [11:0] DSGSR_RUN_CLOCK_CONFIG_OFS = 12'h060;
	localparam logic [11:0] DSGSR_CAPABILITY_1_OFS = 12'h010;
	localparam logic [11:0] DSGSR_INT_STATUS_OFS = 12'h180;
	localparam logic [11:0] DSGSR_INT_MASK_OFS = 12'h184;
	// ==========================================
	// field positions
	localparam int DSGSR_PORTS = 8;
	localparam int DSGSR_BIT_CAN = 24;
	localparam int DSGSR_BIT_ADC = 16;
	localparam int DSGSR_BIT_WATCHDOG = 3;
	localparam int DSGSR_BIT_AUTO_GATE = 27;
	localparam logic [31:0] DSGSR_SRST_MASK = 32'h0101_0008;
	localparam logic [31:0] DSGSR_GATE_MASK = 32'h0000_00ff;
	// ==========================================
	// reset values
	localparam logic [31:0] DSGSR_ZERO_RESET = 32'h0000_0000;
	localparam logic [31:0] DSGSR_CAP1_RESET = 32'h0101_0008;
	// interrupt status bits
	localparam int DSGSR_EV_FAULT = 0;
	localparam int DSGSR_EV_MODE = 1;
	// ==========================================
	// operating states, one-hot
	typedef enum logic [2:0] {
		DSGSR_RUN = 3'b001,
		DSGSR_SLEEP = 3'b010,
		DSGSR_DEEP = 3'b100
	} dsgsr_mode_type;
	// power request codes on the mode input
	localparam logic [1:0] DSGSR_REQ_RUN = 2'h0;
	localparam logic [1:0] DSGSR_REQ_SLEEP = 2'h1;
	localparam logic [1:0] DSGSR_REQ_DEEP = 2'h2;
endpackage
`default_nettype wire

/* File: design/dsgsr_top.sv */
// Contract
// (RL1) deep-sleep gate bits 7..0 enable clocks of ports H..A
// (RL2) port with clear bit in active gate stops; its bus access faults
// (RL3) all gate bits reset to zero, ports start unclocked
// (RL4) run, sleep or deep gate register chosen by operating state
// (RL5) sleep gates used only when auto gating select bit is set
// (RL6) gate bits 31..8 read zero, writes ignored
// (RL7) reset register writes masked by capability word 1
// (RL8) reset bits 24 CAN, 16 converter, 3 watchdog; zero after reset
// (RL9) reserved reset bits read zero, writes ignored
// (RL10) set reset bit holds unit in reset; clear releases it
`default_nettype none
module dsgsr_top
	import dsgsr_pkg::*;
#(
	parameter int PORTS = DSGSR_PORTS
) (
	input wire logic clk, // system clock
	input wire logic reset_n, // sync reset, active low
	input wire logic [11:0] addr, // register byte address
	input wire logic [31:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [31:0] rdata, // read data, cycle after rd
	input wire logic [1:0] power_req, // requested operating state
	input wire logic [PORTS-1:0] port_access, // bus access to a port
	output logic [PORTS-1:0] port_clock_on, // per-port clock enable
	output logic bus_fault, // access to unclocked port
	output logic controller_area_unit_reset, // CAN unit held in reset
	output logic converter_unit_reset, // converter held in reset
	output logic watchdog_unit_reset, // watchdog held in reset
	output logic irq // level interrupt
);
	// ==========================================
	// state
	typedef struct packed {
		logic [PORTS-1:0] run_gate;
		logic [PORTS-1:0] sleep_gate;
		logic [PORTS-1:0] deep_gate;
		logic [31:0] run_clock_config;
		logic [31:0] cap1;
		logic [31:0] soft_reset;
		logic [1:0] int_status;
		logic [1:0] int_mask;
		dsgsr_mode_type mode;
		logic [31:0] rdata;
		logic [PORTS-1:0] clk_on;
		logic fault;
		logic irq;
	} dsgsr_state_type;

	dsgsr_state_type s_q, s_d;
	logic [PORTS-1:0] active_gate;
	logic [1:0] ev;

	// ==========================================
	// next state
	always_comb begin
		s_d = s_q;
		ev = '0;
		// bus writes
		if (wr) begin
			case (addr)
				DSGSR_RUN_GATE_OFS: s_d.run_gate = wdata[PORTS-1:0];
				DSGSR_SLEEP_GATE_OFS: s_d.sleep_gate = wdata[PORTS-1:0];
				DSGSR_DEEP_GATE_OFS: s_d.deep_gate = wdata[PORTS-1:0]; // RL1 RL6
				DSGSR_RUN_CLOCK_CONFIG_OFS: s_d.run_clock_config = wdata;
				DSGSR_CAPABILITY_1_OFS: s_d.cap1 = wdata & DSGSR_SRST_MASK;
				DSGSR_SOFT_RESET_0_OFS: begin
					// masked bits keep their value
					s_d.soft_reset = (wdata & s_q.cap1 & DSGSR_SRST_MASK) // RL7 RL9
						| (s_q.soft_reset & ~s_q.cap1 & DSGSR_SRST_MASK);
				end
				DSGSR_INT_MASK_OFS: s_d.int_mask = wdata[1:0];
				default: ;
			endcase
		end
		// operating state select
		case (power_req)
			DSGSR_REQ_DEEP: s_d.mode = DSGSR_DEEP;
			DSGSR_REQ_SLEEP: s_d.mode = s_q.run_clock_config[DSGSR_BIT_AUTO_GATE]
				? DSGSR_SLEEP : DSGSR_RUN; // RL5
			default: s_d.mode = DSGSR_RUN;
		endcase
		// active gate by mode
		case (s_q.mode)
			DSGSR_SLEEP: active_gate = s_q.sleep_gate; // RL4
			DSGSR_DEEP: active_gate = s_q.deep_gate; // RL4
			default: active_gate = s_q.run_gate;
		endcase
		s_d.clk_on = active_gate; // RL1 RL2
		s_d.fault = |(port_access & ~active_gate); // RL2
		ev[DSGSR_EV_FAULT] = s_d.fault;
		ev[DSGSR_EV_MODE] = s_d.mode != s_q.mode;
		// sticky status: set wins over write-one clear
		if (wr && addr == DSGSR_INT_STATUS_OFS)
			s_d.int_status = s_q.int_status & ~wdata[1:0];
		s_d.int_status = s_d.int_status | ev;
		s_d.irq = |(s_d.int_status & s_d.int_mask);
		// read data
		s_d.rdata = DSGSR_ZERO_RESET;
		if (rd) begin
			case (addr)
				DSGSR_RUN_GATE_OFS: s_d.rdata[PORTS-1:0] = s_q.run_gate;
				DSGSR_SLEEP_GATE_OFS: s_d.rdata[PORTS-1:0] = s_q.sleep_gate;
				DSGSR_DEEP_GATE_OFS: s_d.rdata[PORTS-1:0] = s_q.deep_gate; // RL6
				DSGSR_RUN_CLOCK_CONFIG_OFS: s_d.rdata = s_q.run_clock_config;
				DSGSR_CAPABILITY_1_OFS: s_d.rdata = s_q.cap1;
				DSGSR_SOFT_RESET_0_OFS: s_d.rdata = s_q.soft_reset & DSGSR_SRST_MASK; // RL9
				DSGSR_INT_STATUS_OFS: s_d.rdata[1:0] = s_q.int_status;
				DSGSR_INT_MASK_OFS: s_d.rdata[1:0] = s_q.int_mask;
				default: s_d.rdata = DSGSR_ZERO_RESET;
			endcase
		end
	end

	// ==========================================
	// registers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s_q <= '0; // RL3 RL8
			s_q.cap1 <= DSGSR_CAP1_RESET;
			s_q.mode <= DSGSR_RUN;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from flip-flops
	assign rdata = s_q.rdata;
	assign port_clock_on = s_q.clk_on;
	assign bus_fault = s_q.fault;
	assign controller_area_unit_reset = s_q.soft_reset[DSGSR_BIT_CAN]; // RL10
	assign converter_unit_reset = s_q.soft_reset[DSGSR_BIT_ADC]; // RL10
	assign watchdog_unit_reset = s_q.soft_reset[DSGSR_BIT_WATCHDOG]; // RL10
	assign irq = s_q.irq;
endmodule
`default_nettype wire

/* File: testbench/dsgsr_sva.sv */
`default_nettype none
// ==========================================
// checker on the top ports
module dsgsr_sva #(
	parameter int PORTS = 8
) (
	input wire logic clk, // clock
	input wire logic reset_n, // reset
	input wire logic [11:0] addr, // address
	input wire logic wr, // write
	input wire logic rd, // read
	input wire logic [31:0] rdata, // read data
	input wire logic [1:0] power_req, // mode
	input wire logic [PORTS-1:0] port_access, // access
	input wire logic [PORTS-1:0] port_clock_on, // clocks
	input wire logic bus_fault, // fault
	input wire logic controller_area_unit_reset, // unit reset
	input wire logic converter_unit_reset, // unit reset
	input wire logic watchdog_unit_reset // unit reset
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// read of the reset register, then a quiet spell
	sequence s_rd_srst;
		rd && addr == 12'h040;
	endsequence
	sequence s_quiet;
		(!wr && $stable(power_req)) [*3];
	endsequence
	AST_GATE_RSV: assert property ($past(rd && addr == 12'h128) |-> rdata[31:8] == '0)
		else $error("gate reserved bits set");
	AST_SRST_RSV: assert property (s_rd_srst |=> (rdata & ~32'h0101_0008) == '0)
		else $error("reset reserved bits set");
	AST_SRST_RD: assert property (s_rd_srst |=> rdata[3] == watchdog_unit_reset)
		else $error("reset bit and output differ");
	AST_RST_CHG: assert property ($changed({controller_area_unit_reset, converter_unit_reset,
		watchdog_unit_reset}) |-> $past(wr && addr == 12'h040))
		else $error("unit reset moved without write");
	AST_CLK_CHG: assert property ($changed(port_clock_on) |->
		$past(wr, 2) || $past(wr, 3) || $past(power_req, 2) != $past(power_req, 3))
		else $error("port clocks moved without cause");
	AST_RST_ZERO: assert property ($rose(reset_n) |-> port_clock_on == '0 && !bus_fault)
		else $error("outputs not clear after reset");
	AST_FLT_CAUSE: assert property (bus_fault |-> $past(|port_access))
		else $error("fault without access");
	AST_FLT_GATED: assert property (s_quiet ##0 |(port_access & ~port_clock_on) |=> bus_fault)
		else $error("no fault on gated port");
endmodule
bind dsgsr_top dsgsr_sva #(.PORTS(PORTS)) i_sva (.clk(clk), .reset_n(reset_n), .addr(addr),
	.wr(wr), .rd(rd), .rdata(rdata), .power_req(power_req), .port_access(port_access),
	.port_clock_on(port_clock_on), .bus_fault(bus_fault),
	.controller_area_unit_reset(controller_area_unit_reset),
	.converter_unit_reset(converter_unit_reset), .watchdog_unit_reset(watchdog_unit_reset));
`default_nettype wire

/* File: testbench/testbench.sv */
`default_nettype none
// ==========================================
// bench top
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, reset_n, wr, rd, bus_fault, irq, cr, vr, wdr;
	logic [11:0] addr;
	logic [31:0] wdata, rdata, v;
	logic [1:0] power_req;
	logic [7:0] port_access, port_clock_on;
	int bad_count, tests_run, seed;
	dsgsr_top i_dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .power_req(power_req), .port_access(port_access),
		.port_clock_on(port_clock_on), .bus_fault(bus_fault), .controller_area_unit_reset(cr),
		.converter_unit_reset(vr), .watchdog_unit_reset(wdr), .irq(irq));
	// clock
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask
	// one bus cycle, read data checked in the cycle after
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, exp);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		{wr, rd} <= 2'b00;
		// read data stand between the two edges
		@(negedge clk);
		if (!w) chk(rdata, exp);
		@(posedge clk);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// hang guard
	initial begin
		#40000;
		bad_count++;
		complete_run();
	end
	// main sequence
	initial begin
		seed = 32'h0000_a678;
		{reset_n, wr, rd, addr, wdata, power_req, port_access} = '0;
		repeat (2) @(posedge clk);
		reset_n <= 1;
		@(posedge clk);
		acc(0, 12'h128, 0, 0);
		for (int i = 0; i < 30; i++) begin
			v = $random(seed);
			acc(1, 12'h128, v, 0);
			acc(0, 12'h128, 0, v & 32'h0000_00ff);
			acc(1, 12'h040, v, 0);
			acc(0, 12'h040, 0, v & 32'h0101_0008);
			chk({cr, vr, wdr}, {v[24], v[16], v[3]});
		end
		acc(1, 12'h010, 0, 0);
		acc(1, 12'h040, ~v, 0);
		acc(0, 12'h040, 0, v & 32'h0101_0008);
		port_access <= 8'hff;
		power_req <= 2;
		repeat (4) @(posedge clk);
		chk(port_clock_on, v[7:0]);
		chk(bus_fault, v[7:0] != 8'hff);
		acc(1, 12'h118, 8'h5a, 0);
		power_req <= 1;
		repeat (4) @(posedge clk);
		chk(port_clock_on, 0);
		chk(irq, 0);
		acc(1, 12'h060, 32'h0800_0000, 0);
		acc(1, 12'h184, 1, 0);
		@(posedge clk);
		chk(port_clock_on, 8'h5a);
		chk(irq, 1);
		// code 3 falls back to run gating
		power_req <= 3;
		repeat (3) @(posedge clk);
		chk(port_clock_on, 0);
		port_access <= 0;
		repeat (2) @(posedge clk);
		acc(1, 12'h180, 3, 0);
		@(posedge clk);
		chk(irq, 0);
		complete_run();
	end
endmodule
`default_nettype wire
